// ===== hdl/ssr_pkg.sv
// -----------------------------------------------------------------------------
// shared constants and types of the serial status reporter
// -----------------------------------------------------------------------------
package ssr_pkg;

  // clock, link framing and report timing
  localparam int CLK_HZ            = 100_000_000;
  localparam int BAUD_RATE         = 2400;
  localparam int BIT_CYCLES        = CLK_HZ / BAUD_RATE;
  localparam int DATA_BITS         = 8;
  localparam int STOP_BITS         = 1;
  localparam int REPORT_INTERVAL_S = 2;
  localparam int REPORT_CYCLES     = REPORT_INTERVAL_S * CLK_HZ;

  // line levels and characters
  localparam logic       LINE_IDLE = 1'b1;
  localparam logic       START_LVL = 1'b0;
  localparam logic [7:0] CHR_CR    = 8'h0d;
  localparam logic [7:0] CHR_LF    = 8'h0a;
  localparam logic [7:0] CHR_NUL   = 8'h00;
  localparam logic [7:0] CHR_ZERO  = 8'h30;

  // two-letter commands, first letter in the upper byte
  localparam logic [15:0] START_SPAN_COMMAND    = 16'h6173;
  localparam logic [15:0] START_ZERO_COMMAND    = 16'h617a;
  localparam logic [15:0] REPORT_TOGGLE_COMMAND = 16'h7374;
  localparam logic [1:0]  LINE_CMD_LEN          = 2'h2;
  localparam logic [1:0]  LINE_LEN_SAT          = 2'h3;
  localparam logic        REPORT_ON_RST         = 1'b1;

  // range selector codes
  localparam logic [1:0] RANGE_LOW = 2'h0;
  localparam logic [1:0] RANGE_MED = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;

  // report items in transmit order
  typedef logic [2:0] ssr_item_t;
  localparam ssr_item_t ITEM_CONC  = 3'h0;
  localparam ssr_item_t ITEM_RANGE = 3'h1;
  localparam ssr_item_t ITEM_SPAN  = 3'h2;
  localparam ssr_item_t ITEM_DIS1  = 3'h3;
  localparam ssr_item_t ITEM_DIS2  = 3'h4;
  localparam ssr_item_t ITEM_TRIP1 = 3'h5;
  localparam ssr_item_t ITEM_TRIP2 = 3'h6;
  localparam ssr_item_t ITEM_LAST  = ITEM_TRIP2;
  localparam logic [3:0] POS_FIRST = 4'h0;

  // instrument status as sampled at the start of a report
  typedef struct packed {
    logic [15:0] conc_bcd;
    logic [15:0] span_bcd;
    logic        unit_pct;
    logic [1:0]  range_sel;
    logic [1:0]  alarm_disabled;
    logic [1:0]  alarm_tripped;
  } ssr_status_s;

  // receiver and report sequencer states, gray along the usual path except the sequencer's REP_LF to REP_TEXT step
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } ssr_rx_state_e;

  typedef enum logic [1:0] {
    REP_IDLE = 2'b00,
    REP_TEXT = 2'b01,
    REP_CR   = 2'b11,
    REP_LF   = 2'b10
  } ssr_rep_state_e;

endpackage

// ===== hdl/ssr_uart_tx.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// serialiser: start bit, data lsb first, stop bits
// -----------------------------------------------------------------------------
module ssr_uart_tx
  import ssr_pkg::*;
#(
  parameter int P_BIT_CYCLES = BIT_CYCLES
) (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  // character in
  input  wire logic       i_vld,
  input  wire logic [7:0] i_data,
  output logic            o_rdy,
  // serial line
  output logic            o_txd
);

  localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
  localparam int IDX_W      = $clog2(FRAME_BITS);
  localparam int CNT_W      = $clog2(P_BIT_CYCLES + 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(P_BIT_CYCLES - 1);

  if (P_BIT_CYCLES < 2) begin : g_chk_bit
    $error("bit period must be at least two clocks");
  end

  logic [DATA_BITS+STOP_BITS-1:0] shift_ff;
  logic [IDX_W-1:0]               idx_ff;
  logic [CNT_W-1:0]               cnt_ff;

  // one frame at a time; ready only returns after the full stop bit
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_ff <= '1;
      idx_ff   <= '0;
      cnt_ff   <= '0;
      o_rdy    <= 1'b1;
      o_txd    <= LINE_IDLE;
    end else if (o_rdy) begin
      if (i_vld) begin
        o_rdy    <= 1'b0;
        o_txd    <= START_LVL;
        shift_ff <= {{STOP_BITS{LINE_IDLE}}, i_data};
        idx_ff   <= '0;
        cnt_ff   <= '0;
      end
    end else if (cnt_ff == BIT_LAST) begin
      cnt_ff <= '0;
      if (idx_ff == IDX_LAST) begin
        o_rdy <= 1'b1;
      end else begin
        o_txd    <= shift_ff[0];
        shift_ff <= {LINE_IDLE, shift_ff[DATA_BITS+STOP_BITS-1:1]};
        idx_ff   <= idx_ff + 1'b1;
      end
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // a taken character opens with a low start bit
  a_tx_start_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (o_rdy && i_vld) |=> (!o_txd && !o_rdy))
    else $error("start bit not driven low");

  // the last bit of every frame is a high stop bit
  a_tx_stop_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_rdy && idx_ff == IDX_LAST) |-> o_txd)
    else $error("stop bit not high");

endmodule

// ===== hdl/ssr_serial_status_reporter.sv
`timescale 1ns/10ps
module ssr_serial_status_reporter
  import ssr_pkg::*;
#(
  parameter int P_BIT_CYCLES    = BIT_CYCLES,
  parameter int P_REPORT_CYCLES = REPORT_CYCLES
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // serial pins
  input  wire logic        i_rxd,
  output logic             o_txd,
  // instrument status and control
  input  wire ssr_status_s i_status,
  output logic             o_span_start,
  output logic             o_zero_start,
  output logic             o_report_on
);

  localparam int BIT_W = $clog2(P_BIT_CYCLES + 1);
  localparam int REP_W = $clog2(P_REPORT_CYCLES + 1);
  localparam logic [BIT_W-1:0] BIT_LAST  = BIT_W'(P_BIT_CYCLES - 1);
  localparam logic [BIT_W-1:0] HALF_LAST = BIT_W'(P_BIT_CYCLES / 2 - 1);
  localparam logic [REP_W-1:0] REP_LAST  = REP_W'(P_REPORT_CYCLES - 1);
  localparam logic [2:0]       RX_IDX_LAST = 3'(DATA_BITS - 1);

  if (P_BIT_CYCLES < 4 || P_REPORT_CYCLES < 2) begin : g_chk_time
    $error("bit period or report interval too short");
  end

  // -----------------------------------------------------------------------------
  // text helpers
  // -----------------------------------------------------------------------------
  function automatic logic [31:0] ascii4(input logic [15:0] bcd);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[8*i +: 8] = CHR_ZERO | {4'h0, bcd[4*i +: 4]};
    end
    return r;
  endfunction

  // one character of an item, nul past its end
  function automatic logic [7:0] text_char(input ssr_item_t it, input logic [3:0] pos,
                                           input ssr_status_s stat);
    logic [0:15][7:0] s;
    logic [31:0]      cd;
    logic [31:0]      sd;
    cd = ascii4(stat.conc_bcd);
    sd = ascii4(stat.span_bcd);
    case (it)
      ITEM_CONC:  s = stat.unit_pct ? {cd, " %", 80'h0} : {cd, " ppm", 64'h0};
      ITEM_RANGE: begin
        case (stat.range_sel)
          RANGE_LOW: s = {"LO", 112'h0};
          RANGE_MED: s = {"MED", 104'h0};
          default:   s = {"HI", 112'h0};
        endcase
      end
      ITEM_SPAN:  s = stat.unit_pct ? {"0-", sd, " %", 64'h0} : {"0-", sd, " ppm", 48'h0};
      ITEM_DIS1:  s = {"AL-1 DISABLED", 24'h0};
      ITEM_DIS2:  s = {"AL-2 DISABLED", 24'h0};
      ITEM_TRIP1: s = {"AL-1 ON", 72'h0};
      ITEM_TRIP2: s = {"AL-2 ON", 72'h0};
      default:    s = '0;
    endcase
    return s[pos];
  endfunction

  // alarm items only appear when that alarm is disabled or tripped
  function automatic logic item_on(input ssr_item_t it, input ssr_status_s stat);
    case (it)
      ITEM_DIS1:  return stat.alarm_disabled[0];
      ITEM_DIS2:  return stat.alarm_disabled[1];
      ITEM_TRIP1: return stat.alarm_tripped[0];
      ITEM_TRIP2: return stat.alarm_tripped[1];
      default:    return 1'b1;
    endcase
  endfunction

  // -----------------------------------------------------------------------------
  // receive path
  // -----------------------------------------------------------------------------
  logic          rxd_m1_ff, rxd_m2_ff, rxd_m3_ff, rxd_lvl_ff;
  ssr_rx_state_e rx_state_ff;
  logic [BIT_W-1:0] rx_cnt_ff;
  logic [2:0]    rx_idx_ff;
  logic [7:0]    rx_shift_ff;
  logic          rx_vld_ff;
  logic          rx_err_ff;

  // pin synchroniser; the level moves only when stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rxd_m1_ff  <= LINE_IDLE;
      rxd_m2_ff  <= LINE_IDLE;
      rxd_m3_ff  <= LINE_IDLE;
      rxd_lvl_ff <= LINE_IDLE;
    end else begin
      rxd_m1_ff <= i_rxd;
      rxd_m2_ff <= rxd_m1_ff;
      rxd_m3_ff <= rxd_m2_ff;
      if (rxd_m2_ff == rxd_m3_ff) begin
        rxd_lvl_ff <= rxd_m3_ff;
      end
    end
  end

  // receiver samples mid-bit and never waits on the transmitter
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff   <= '0;
      rx_idx_ff   <= '0;
      rx_shift_ff <= '0;
      rx_vld_ff   <= 1'b0;
      rx_err_ff   <= 1'b0;
    end else begin
      rx_vld_ff <= 1'b0;
      rx_err_ff <= 1'b0;
      case (rx_state_ff)
        RX_IDLE: begin
          rx_cnt_ff <= '0;
          if (rxd_lvl_ff == START_LVL) begin
            rx_state_ff <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_ff == HALF_LAST) begin
            rx_cnt_ff   <= '0;
            rx_idx_ff   <= '0;
            // a start bit gone by mid-bit was a glitch
            rx_state_ff <= (rxd_lvl_ff == START_LVL) ? RX_DATA : RX_IDLE;
          end else begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_cnt_ff == BIT_LAST) begin
            rx_cnt_ff   <= '0;
            rx_shift_ff <= {rxd_lvl_ff, rx_shift_ff[7:1]};
            rx_idx_ff   <= rx_idx_ff + 1'b1;
            if (rx_idx_ff == RX_IDX_LAST) begin
              rx_state_ff <= RX_STOP;
            end
          end else begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
        RX_STOP: begin
          if (rx_cnt_ff == BIT_LAST) begin
            rx_state_ff <= RX_IDLE;
            rx_vld_ff   <= rxd_lvl_ff;
            rx_err_ff   <= ~rxd_lvl_ff;
          end else begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------------
  // command line parser
  // -----------------------------------------------------------------------------
  logic [15:0] cmd_chars_ff;
  logic [1:0]  line_len_ff;
  logic        line_bad_ff;
  logic        line_end, line_ok, hit_span, hit_zero, hit_toggle;

  assign line_end   = rx_vld_ff && (rx_shift_ff == CHR_CR);
  assign line_ok    = line_end && !line_bad_ff && (line_len_ff == LINE_CMD_LEN);
  assign hit_span   = line_ok && (cmd_chars_ff == START_SPAN_COMMAND);
  assign hit_zero   = line_ok && (cmd_chars_ff == START_ZERO_COMMAND);
  assign hit_toggle = line_ok && (cmd_chars_ff == REPORT_TOGGLE_COMMAND);

  // keeps the last two letters; line feeds are skipped so crlf terminals work
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd_chars_ff <= '0;
      line_len_ff  <= '0;
      line_bad_ff  <= 1'b0;
    end else if (rx_err_ff) begin
      line_bad_ff <= 1'b1;
    end else if (line_end) begin
      line_len_ff <= '0;
      line_bad_ff <= 1'b0;
    end else if (rx_vld_ff && rx_shift_ff != CHR_LF) begin
      cmd_chars_ff <= {cmd_chars_ff[7:0], rx_shift_ff};
      if (line_len_ff != LINE_LEN_SAT) begin
        line_len_ff <= line_len_ff + 1'b1;
      end
    end
  end

  // calibration starts are one-cycle pulses; reporting is a level
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_span_start <= 1'b0;
      o_zero_start <= 1'b0;
      o_report_on  <= REPORT_ON_RST;
    end else begin
      o_span_start <= hit_span;
      o_zero_start <= hit_zero;
      o_report_on  <= o_report_on ^ hit_toggle;
    end
  end

  // -----------------------------------------------------------------------------
  // report interval and sequencer
  // -----------------------------------------------------------------------------
  logic [REP_W-1:0] rep_cnt_ff;
  logic             rep_tick_ff;
  ssr_rep_state_e   rep_state_ff;
  ssr_status_s      snap_ff;
  ssr_item_t        item_ff;
  logic [3:0]       pos_ff;
  logic [7:0]       cur_char;
  logic             cur_on;
  logic             tx_vld;
  logic [7:0]       tx_data;
  logic             tx_rdy;

  // free-running interval; a tick while a report is still out is dropped
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rep_cnt_ff  <= '0;
      rep_tick_ff <= 1'b0;
    end else begin
      rep_tick_ff <= (rep_cnt_ff == REP_LAST);
      rep_cnt_ff  <= (rep_cnt_ff == REP_LAST) ? '0 : rep_cnt_ff + 1'b1;
    end
  end

  assign cur_char = text_char(item_ff, pos_ff, snap_ff);
  assign cur_on   = item_on(item_ff, snap_ff);

  // character offered to the serialiser
  always_comb begin
    tx_vld  = 1'b0;
    tx_data = cur_char;
    case (rep_state_ff)
      REP_TEXT: tx_vld = o_report_on && cur_on && (cur_char != CHR_NUL);
      REP_CR: begin
        tx_vld  = 1'b1;
        tx_data = CHR_CR;
      end
      REP_LF: begin
        tx_vld  = 1'b1;
        tx_data = CHR_LF;
      end
      default: tx_vld = 1'b0;
    endcase
  end

  // status is frozen at report start so one report never mixes two samples
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rep_state_ff <= REP_IDLE;
      snap_ff      <= '0;
      item_ff      <= ITEM_CONC;
      pos_ff       <= POS_FIRST;
    end else begin
      case (rep_state_ff)
        REP_IDLE: begin
          if (rep_tick_ff && o_report_on) begin
            snap_ff      <= i_status;
            item_ff      <= ITEM_CONC;
            pos_ff       <= POS_FIRST;
            rep_state_ff <= REP_TEXT;
          end
        end
        REP_TEXT: begin
          if (!o_report_on) begin
            rep_state_ff <= REP_IDLE;
          end else if (!cur_on) begin
            pos_ff <= POS_FIRST;
            if (item_ff == ITEM_LAST) begin
              rep_state_ff <= REP_IDLE;
            end else begin
              item_ff <= item_ff + 1'b1;
            end
          end else if (cur_char == CHR_NUL) begin
            rep_state_ff <= REP_CR;
          end else if (tx_rdy) begin
            pos_ff <= pos_ff + 1'b1;
          end
        end
        REP_CR: begin
          if (tx_rdy) begin
            rep_state_ff <= REP_LF;
          end
        end
        REP_LF: begin
          if (tx_rdy) begin
            pos_ff       <= POS_FIRST;
            item_ff      <= item_ff + 1'b1;
            rep_state_ff <= (item_ff == ITEM_LAST) ? REP_IDLE : REP_TEXT;
          end
        end
        default: rep_state_ff <= REP_IDLE;
      endcase
    end
  end

  ssr_uart_tx #(
    .P_BIT_CYCLES (P_BIT_CYCLES)
  ) u_tx (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_vld      (tx_vld),
    .i_data     (tx_data),
    .o_rdy      (tx_rdy),
    .o_txd      (o_txd)
  );

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  a_rx_collects_char: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_vld_ff && !rx_err_ff && rx_shift_ff != CHR_CR && rx_shift_ff != CHR_LF)
      |=> cmd_chars_ff[7:0] == $past(rx_shift_ff))
    else $error("received character not collected");

  a_report_starts: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rep_tick_ff && o_report_on && rep_state_ff == REP_IDLE)
      |=> (rep_state_ff == REP_TEXT && item_ff == ITEM_CONC && pos_ff == POS_FIRST))
    else $error("report did not start on interval tick");

  a_report_held_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rep_state_ff == REP_IDLE && !o_report_on) |=> rep_state_ff == REP_IDLE)
    else $error("report started while reporting stopped");

  a_item_order_up: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rep_state_ff != REP_IDLE && $past(rep_state_ff) != REP_IDLE)
      |-> item_ff >= $past(item_ff))
    else $error("report items out of order");

  a_cr_then_lf: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rep_state_ff == REP_CR && tx_rdy) |=> (rep_state_ff == REP_LF && tx_data == CHR_LF))
    else $error("carriage return not followed by line feed");

  a_span_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    hit_span |=> o_span_start ##1 !o_span_start)
    else $error("span start not a single pulse");

  a_zero_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    hit_zero |=> o_zero_start ##1 !o_zero_start)
    else $error("zero start not a single pulse");

  a_toggle_flips: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    hit_toggle |=> o_report_on != $past(o_report_on))
    else $error("toggle command did not flip reporting");

  a_bad_line_dropped: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (line_end && !line_ok) |=> (!o_span_start && !o_zero_start && $stable(o_report_on)))
    else $error("unrecognised line had an effect");

endmodule

// ===== verification/ssr_host_model.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// host terminal model: 8n1 sender and listener on the far side of the port
// -----------------------------------------------------------------------------
module ssr_host_model #(
  parameter int P_BIT_CYCLES = 8
) (
  // clock
  input  wire logic i_core_clk,
  // serial pins seen from the host
  input  wire logic i_txd,
  output logic      o_rxd
);
  logic [7:0] rx_q[$];  // characters heard from the device
  int         t_q[$];   // cycle of each start bit heard
  int         cyc = 0;

  // free cycle count, used to time report starts
  always @(posedge i_core_clk) cyc <= cyc + 1;

  // line rests high between frames
  initial o_rxd = 1'b1;

  // one character: start bit, eight data bits lsb first, one stop bit, no parity
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int b = 0; b < 10; b++) begin
      o_rxd <= frame[b];
      repeat (P_BIT_CYCLES) @(posedge i_core_clk);
    end
  endtask

  // typed letters then the enter terminator
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) send_char(s[i]);
    send_char(8'h0d);
  endtask

  // a frame with a low stop bit, then idle long enough for the receiver to resync
  task automatic send_bad(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b0, ch, 1'b0};
    for (int b = 0; b < 10; b++) begin
      o_rxd <= frame[b];
      repeat (P_BIT_CYCLES) @(posedge i_core_clk);
    end
    o_rxd <= 1'b1;
    repeat (2 * P_BIT_CYCLES) @(posedge i_core_clk);
  endtask

  // listener samples mid-cell; a bad stop bit is stored as 0xff so it never matches
  initial begin
    logic [7:0] ch;
    forever begin
      @(negedge i_txd);
      // stamp on the next edge, where cyc is read before its own update
      @(posedge i_core_clk);
      t_q.push_back(cyc);
      repeat (P_BIT_CYCLES / 2 - 1) @(posedge i_core_clk);
      for (int b = 0; b < 8; b++) begin
        repeat (P_BIT_CYCLES) @(posedge i_core_clk);
        ch[b] = i_txd;
      end
      repeat (P_BIT_CYCLES) @(posedge i_core_clk);
      rx_q.push_back((i_txd === 1'b1) ? ch : 8'hff);
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// self-checking bench: reports, commands and refused lines
// -----------------------------------------------------------------------------
module testbench;
  import ssr_pkg::*;
  localparam int BITC = 8;
  localparam int REPC = 20000;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b    = 1'b0;
  logic        rxd;
  logic        txd;
  logic        span_go;
  logic        zero_go;
  logic        rep_on;
  ssr_status_s stat;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          span_n          = 0;
  int          zero_n          = 0;
  int          last_start      = 0;

  always #5 i_core_clk = ~i_core_clk;

  ssr_serial_status_reporter #(.P_BIT_CYCLES(BITC), .P_REPORT_CYCLES(REPC))
    ssr_serial_status_reporter_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_rxd(rxd),
    .o_txd(txd), .i_status(stat), .o_span_start(span_go), .o_zero_start(zero_go),
    .o_report_on(rep_on));

  ssr_host_model #(.P_BIT_CYCLES(BITC)) ssr_host_model_i (.i_core_clk(i_core_clk),
    .i_txd(txd), .o_rxd(rxd));

  // pulse counters count high cycles, so a stretched pulse shows as a wrong count
  always @(posedge i_core_clk) begin
    if (span_go === 1'b1) span_n++;
    if (zero_go === 1'b1) zero_n++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // expected report text; digits are bcd so hex printing gives them directly
  function automatic string rep_text(ssr_status_s s);
    string u;
    string rng;
    string nl;
    string r;
    u = " ppm";
    if (s.unit_pct) u = " %";
    rng = "HI";
    if (s.range_sel == RANGE_LOW) rng = "LO";
    else if (s.range_sel == RANGE_MED) rng = "MED";
    nl = "\015\012";
    r = {$sformatf("%h", s.conc_bcd), u, nl};
    r = {r, rng, nl};
    r = {r, "0-", $sformatf("%h", s.span_bcd), u, nl};
    for (int i = 0; i < 2; i++)
      if (s.alarm_disabled[i]) r = {r, $sformatf("AL-%0d DISABLED", i + 1), nl};
    for (int i = 0; i < 2; i++)
      if (s.alarm_tripped[i]) r = {r, $sformatf("AL-%0d ON", i + 1), nl};
    return r;
  endfunction

  // new status while the line is idle; only bcd digits, the design refuses nothing here
  task automatic rand_status();
    ssr_status_s s;
    for (int i = 0; i < 4; i++) begin
      s.conc_bcd[i*4 +: 4] = 4'($urandom % 10);
      s.span_bcd[i*4 +: 4] = 4'($urandom % 10);
    end
    {s.unit_pct, s.range_sel, s.alarm_disabled, s.alarm_tripped} = 7'($urandom);
    stat <= s;
    @(posedge i_core_clk);
  endtask

  // wait for a whole report, then let extra characters show before comparing
  task automatic get_report(input string exp, input bit timed);
    int n = 0;
    while (ssr_host_model_i.rx_q.size() < exp.len() && n < 3 * REPC) begin
      @(posedge i_core_clk);
      n++;
    end
    repeat (40 * BITC) @(posedge i_core_clk);
    check("report length", ssr_host_model_i.rx_q.size(), exp.len());
    if (timed && ssr_host_model_i.t_q.size() > 0)
      check("report interval", ssr_host_model_i.t_q[0] - last_start, REPC);
    if (ssr_host_model_i.t_q.size() > 0) last_start = ssr_host_model_i.t_q[0];
    for (int i = 0; i < exp.len() && i < ssr_host_model_i.rx_q.size(); i++)
      check("report char", ssr_host_model_i.rx_q[i], exp[i]);
    ssr_host_model_i.rx_q.delete();
    ssr_host_model_i.t_q.delete();
  endtask

  // watchdog, past the four report periods the sequence needs
  initial begin
    repeat (5 * REPC) @(posedge i_core_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    void'($urandom(16));
    // corner first: zero and nine digits, every alarm item, range code 3
    stat <= '{conc_bcd: 16'h0000, span_bcd: 16'h9999, unit_pct: 1'b1, range_sel: 2'h3,
              alarm_disabled: 2'h3, alarm_tripped: 2'h3};
    repeat (5) @(posedge i_core_clk);
    check("txd in reset", txd, 1'b1);
    check("report on in reset", rep_on, 1'b1);
    i_rst_b <= 1'b1;
    // span typed while the first report streams out
    fork
      get_report(rep_text(stat), 1'b0);
      begin
        wait (ssr_host_model_i.t_q.size() > 0);
        ssr_host_model_i.send_line("as");
      end
    join
    check("span pulses", span_n, 1);
    check("zero pulses", zero_n, 0);
    // refused lines: wrong letters, wrong case, too long, stale letters, framing error
    rand_status();
    ssr_host_model_i.send_line("ax");
    ssr_host_model_i.send_line("AS");
    ssr_host_model_i.send_line("xas");
    ssr_host_model_i.send_line("a");
    ssr_host_model_i.send_line("s");
    ssr_host_model_i.send_char(8'h61);
    ssr_host_model_i.send_char(8'h73);
    ssr_host_model_i.send_bad(8'h73);
    ssr_host_model_i.send_char(8'h0d);
    // zero followed by a stray line feed
    ssr_host_model_i.send_line("az");
    ssr_host_model_i.send_char(8'h0a);
    repeat (4) @(posedge i_core_clk);
    check("span pulses", span_n, 1);
    check("zero pulses", zero_n, 1);
    check("report on", rep_on, 1'b1);
    get_report(rep_text(stat), 1'b1);
    // toggle off: a full period passes silent, then toggle back on
    ssr_host_model_i.send_line("st");
    repeat (4) @(posedge i_core_clk);
    check("report off", rep_on, 1'b0);
    repeat (REPC + 200) @(posedge i_core_clk);
    check("silent chars", ssr_host_model_i.rx_q.size(), 0);
    rand_status();
    ssr_host_model_i.send_line("st");
    repeat (4) @(posedge i_core_clk);
    check("report on again", rep_on, 1'b1);
    get_report(rep_text(stat), 1'b0);
    check("span pulses", span_n, 1);
    end_sim();
  end
endmodule
